// ---- logic/sla_defines.vh ----
`ifndef SLA_DEFINES_VH
`define SLA_DEFINES_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define SLA_OFS_CONTROL   8'h00
`define SLA_OFS_EMPHASIS  8'h04
`define SLA_OFS_ALM_STAT  8'h08
`define SLA_OFS_ALARM_MASK_BITS  8'h0c
`define SLA_OFS_SUMMARY   8'h10
`define SLA_OFS_LANE_FIFO 8'h14
`define SLA_OFS_FRAMING   8'h18
`define SLA_OFS_STATE     8'h1c

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define SLA_CTL_LINK_EN   0
`define SLA_CTL_ENC64     1
`define SLA_CTL_SUBCLASS1 2
`define SLA_CTL_PIN_ALARM 3
`define SLA_CTL_PD_A      4
`define SLA_CTL_PD_B      5
`define SLA_CTL_WIDTH     6

// ----------------------------------------------------------------------------
// alarm status / mask bit positions
// ----------------------------------------------------------------------------
`define SLA_ALM_CPLL      0
`define SLA_ALM_SPLL      1
`define SLA_ALM_LINK      2
`define SLA_ALM_SYSREF    3
`define SLA_ALM_CLK       4
`define SLA_ALM_FIFO      5
`define SLA_ALM_COUNT     6

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SLA_RST_CONTROL   6'h04
`define SLA_RST_EMPHASIS  4'h0
`define SLA_RST_ALARM_MASK_BITS  6'h00
`define SLA_RST_FRAME_LEN 16'h0020
`define SLA_RST_EMB_LEN   8'h01

// ----------------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------------
`define SLA_RESP_OKAY     2'b00
`define SLA_RESP_SLVERR   2'b10

`endif

// ---- logic/sla_link_control.v ----
// What this block does
// - programmable serializer pre-emphasis level
// - link disabled: reset, power down, gate clocks
// - SYSREF resets LMFC or LEMC by encoding
// - subclass 0: free-running clock, SYNC starts CGS except in 64b/66b
// - detect six alarm conditions
// - sticky alarm bits cleared by writing one
// - unmasked alarms reported in summary alarm
// - status pin may act as alarm output
// - channel clock mismatch sets sticky upset flag
// - lane FIFO pointer upset sets lane flag
// - link enable toggle resets FIFO logic
// - end-of-extended bit high only last multiblock
//
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "sla_defines.vh"

module sla_link_control #(
    parameter LANES   = 8,
    parameter EMPH_W  = 4
) (
    // clock and reset
    input  wire                 clock,
    input  wire                 reset,
    // axi4-lite write address and data
    input  wire [7:0]           s_axi_awaddr,
    input  wire                 s_axi_awvalid,
    output wire                 s_axi_awready,
    input  wire [31:0]          s_axi_wdata,
    input  wire [3:0]           s_axi_wstrb,
    input  wire                 s_axi_wvalid,
    output wire                 s_axi_wready,
    // axi4-lite write response
    output reg  [1:0]           s_axi_bresp,
    output reg                  s_axi_bvalid,
    input  wire                 s_axi_bready,
    // axi4-lite read
    input  wire [7:0]           s_axi_araddr,
    input  wire                 s_axi_arvalid,
    output wire                 s_axi_arready,
    output reg  [31:0]          s_axi_rdata,
    output reg  [1:0]           s_axi_rresp,
    output reg                  s_axi_rvalid,
    input  wire                 s_axi_rready,
    // pins from outside the clock domain
    input  wire                 converterPllLock,
    input  wire                 serializerPllLock,
    input  wire                 sysrefPin,
    input  wire                 syncRequestN,
    // same-clock status from the link and clock logic
    input  wire                 linkInDataState,
    input  wire                 channelAPhase,
    input  wire                 channelBPhase,
    input  wire [LANES-1:0]     laneFifoPointerUpset,
    input  wire                 calDone,
    // link section control
    output reg                  linkReset,
    output reg                  serializerPowerDown,
    output reg                  linkClockEnable,
    output reg                  fifoReset,
    output reg  [EMPH_W-1:0]    serializerEmphasisLevel,
    output reg                  powerdownChannelA,
    output reg                  powerdownChannelB,
    // local multiframe / extended multiblock clock
    output reg                  localClockEdge,
    output reg                  endOfExtMultiblock,
    output reg                  codeGroupSyncStart,
    // alarm reporting
    output reg                  summaryAlarm,
    output reg                  calStatePin
);

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    reg [3:0] pinMeta;
    reg [3:0] pinSync;
    reg       sysrefLast;

    // two flops per pin; only the second stage is read below
    always @(posedge clock) begin
        if (reset) begin
            pinMeta    <= 4'h0;
            pinSync    <= 4'h0;
            sysrefLast <= 1'b0;
        end else begin
            pinMeta    <= {syncRequestN, sysrefPin, serializerPllLock, converterPllLock};
            pinSync    <= pinMeta;
            sysrefLast <= pinSync[2];
        end
    end

    wire cpllLocked   = pinSync[0];
    wire spllLocked   = pinSync[1];
    wire sysrefRise   = pinSync[2] & ~sysrefLast;
    wire syncAsserted = ~pinSync[3];

    // ------------------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------------------
    reg [`SLA_CTL_WIDTH-1:0] control;
    reg [`SLA_ALM_COUNT-1:0] alarmStatusBits;
    reg [`SLA_ALM_COUNT-1:0] alarmMaskBits;
    reg [LANES-1:0]          laneFifoErrorFlags;
    reg [15:0]               frameLength;
    reg [7:0]                extMultiblockLength;

    wire linkEnable = control[`SLA_CTL_LINK_EN];
    wire enc64      = control[`SLA_CTL_ENC64];
    wire subclass1  = control[`SLA_CTL_SUBCLASS1];
    wire pinAlarm   = control[`SLA_CTL_PIN_ALARM];

    // ------------------------------------------------------------------------
    // axi4-lite write path
    // ------------------------------------------------------------------------
    reg        awHeld;
    reg        wHeld;
    reg [7:0]  awAddr;
    reg [31:0] wData;
    reg [3:0]  wStrb;

    // address and data are taken in either order, one write at a time
    assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
    assign s_axi_wready  = ~wHeld & ~s_axi_bvalid;

    wire [7:0]  curAwAddr = awHeld ? awAddr : s_axi_awaddr;
    wire [31:0] curWData  = wHeld ? wData : s_axi_wdata;
    wire [3:0]  curWStrb  = wHeld ? wStrb : s_axi_wstrb;
    wire        haveAw    = awHeld | (s_axi_awvalid & s_axi_awready);
    wire        haveW     = wHeld | (s_axi_wvalid & s_axi_wready);
    wire        doWrite   = haveAw & haveW & ~s_axi_bvalid;

    // byte-lane expansion of the strobes
    wire [31:0] laneMask = {{8{curWStrb[3]}}, {8{curWStrb[2]}},
                            {8{curWStrb[1]}}, {8{curWStrb[0]}}};
    wire [31:0] wBits    = curWData & laneMask;

    wire wrControl  = doWrite & (curAwAddr == `SLA_OFS_CONTROL);
    wire wrEmphasis = doWrite & (curAwAddr == `SLA_OFS_EMPHASIS);
    wire wrAlmStat  = doWrite & (curAwAddr == `SLA_OFS_ALM_STAT);
    wire wrAlmMask  = doWrite & (curAwAddr == `SLA_OFS_ALARM_MASK_BITS);
    wire wrLaneFifo = doWrite & (curAwAddr == `SLA_OFS_LANE_FIFO);
    wire wrFraming  = doWrite & (curAwAddr == `SLA_OFS_FRAMING);
    wire wrMapped   = wrControl | wrEmphasis | wrAlmStat | wrAlmMask | wrLaneFifo
                      | wrFraming | (curAwAddr == `SLA_OFS_SUMMARY)
                      | (curAwAddr == `SLA_OFS_STATE);

    // holding registers and response
    always @(posedge clock) begin
        if (reset) begin
            awHeld       <= 1'b0;
            wHeld        <= 1'b0;
            awAddr       <= 8'h00;
            wData        <= 32'h0000_0000;
            wStrb        <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `SLA_RESP_OKAY;
        end else begin
            if (doWrite) begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wrMapped ? `SLA_RESP_OKAY : `SLA_RESP_SLVERR;
            end else begin
                if (s_axi_awvalid & s_axi_awready) begin
                    awHeld <= 1'b1;
                    awAddr <= s_axi_awaddr;
                end
                if (s_axi_wvalid & s_axi_wready) begin
                    wHeld <= 1'b1;
                    wData <= s_axi_wdata;
                    wStrb <= s_axi_wstrb;
                end
                if (s_axi_bvalid & s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // plain control registers
    // ------------------------------------------------------------------------
    always @(posedge clock) begin
        if (reset) begin
            control             <= `SLA_RST_CONTROL;
            serializerEmphasisLevel <= `SLA_RST_EMPHASIS;
            alarmMaskBits       <= `SLA_RST_ALARM_MASK_BITS;
            frameLength         <= `SLA_RST_FRAME_LEN;
            extMultiblockLength <= `SLA_RST_EMB_LEN;
        end else begin
            if (wrControl) begin
                control <= wBits[`SLA_CTL_WIDTH-1:0];
            end
            if (wrEmphasis) begin
                serializerEmphasisLevel <= wBits[EMPH_W-1:0];
            end
            if (wrAlmMask) begin
                alarmMaskBits <= wBits[`SLA_ALM_COUNT-1:0];
            end
            // zero lengths would run the counters to full range before wrapping, so they are ignored
            if (wrFraming & (wBits[15:0] != 16'h0000)) begin
                frameLength <= wBits[15:0];
            end
            if (wrFraming & (wBits[23:16] != 8'h00)) begin
                extMultiblockLength <= wBits[23:16];
            end
        end
    end

    // ------------------------------------------------------------------------
    // link section enable effects
    // ------------------------------------------------------------------------
    reg linkEnableLast;

    // every effect is a flop, one cycle behind the control bits it follows
    always @(posedge clock) begin
        if (reset) begin
            linkReset           <= 1'b1;
            serializerPowerDown <= 1'b1;
            linkClockEnable     <= 1'b0;
            fifoReset           <= 1'b1;
            linkEnableLast      <= 1'b0;
            powerdownChannelA   <= 1'b0;
            powerdownChannelB   <= 1'b0;
            codeGroupSyncStart  <= 1'b0;
        end else begin
            linkReset           <= ~linkEnable;
            serializerPowerDown <= ~linkEnable;
            linkClockEnable     <= linkEnable;
            fifoReset           <= ~linkEnable;
            linkEnableLast      <= linkEnable;
            powerdownChannelA   <= control[`SLA_CTL_PD_A];
            powerdownChannelB   <= control[`SLA_CTL_PD_B];
            codeGroupSyncStart  <= linkEnable & ~enc64 & syncAsserted;
        end
    end

    // ------------------------------------------------------------------------
    // local multiframe / extended multiblock clock
    // ------------------------------------------------------------------------
    reg [15:0] frameCount;
    reg [7:0]  multiblockIndex;
    reg        sysrefRealign;
    wire frameWrap = (frameCount == frameLength - 16'h0001);
    wire embWrap   = (multiblockIndex == extMultiblockLength - 8'h01);
    wire useSysref = subclass1 & sysrefRise;
    wire phaseOff  = (frameCount != 16'h0000) | (enc64 & (multiblockIndex != 8'h00));
    // in subclass 0 the counter free-runs with whatever phase it started in
    always @(posedge clock) begin
        if (reset | ~linkEnable) begin
            frameCount         <= 16'h0000;
            multiblockIndex    <= 8'h00;
            localClockEdge     <= 1'b0;
            endOfExtMultiblock <= 1'b0;
            sysrefRealign      <= 1'b0;
        end else begin
            sysrefRealign <= useSysref & phaseOff;
            if (useSysref) begin
                frameCount      <= 16'h0000;
                multiblockIndex <= 8'h00;
                localClockEdge  <= 1'b1;
            end else if (frameWrap) begin
                frameCount <= 16'h0000;
                if (enc64) begin
                    multiblockIndex <= embWrap ? 8'h00 : multiblockIndex + 8'h01;
                    localClockEdge  <= embWrap;
                end else begin
                    multiblockIndex <= 8'h00;
                    localClockEdge  <= 1'b1;
                end
            end else begin
                frameCount     <= frameCount + 16'h0001;
                localClockEdge <= 1'b0;
            end
            // bit sent with the current multiblock
            endOfExtMultiblock <= enc64 & embWrap;
        end
    end

    // ------------------------------------------------------------------------
    // alarm detection
    // ------------------------------------------------------------------------
    // clock compare only means something with both channels up and the link on
    wire clockUpset = linkEnable & ~control[`SLA_CTL_PD_A] & ~control[`SLA_CTL_PD_B]
                      & (channelAPhase != channelBPhase);
    wire [LANES-1:0] laneUpset = linkEnable ? laneFifoPointerUpset : {LANES{1'b0}};
    wire [`SLA_ALM_COUNT-1:0] alarmEvents;
    assign alarmEvents[`SLA_ALM_CPLL]   = ~cpllLocked;
    assign alarmEvents[`SLA_ALM_SPLL]   = ~spllLocked;
    assign alarmEvents[`SLA_ALM_LINK]   = ~linkInDataState;
    assign alarmEvents[`SLA_ALM_SYSREF] = sysrefRealign;
    assign alarmEvents[`SLA_ALM_CLK]    = clockUpset;
    assign alarmEvents[`SLA_ALM_FIFO]   = |laneUpset;
    wire [`SLA_ALM_COUNT-1:0] almClear  = wrAlmStat ? wBits[`SLA_ALM_COUNT-1:0]
                                                    : {`SLA_ALM_COUNT{1'b0}};
    wire [LANES-1:0]          laneClear = wrLaneFifo ? wBits[LANES-1:0] : {LANES{1'b0}};
    // sticky bits: a new event in the clearing cycle wins over the clear
    always @(posedge clock) begin
        if (reset) begin
            alarmStatusBits    <= {`SLA_ALM_COUNT{1'b0}};
            laneFifoErrorFlags <= {LANES{1'b0}};
        end else begin
            alarmStatusBits    <= (alarmStatusBits & ~almClear) | alarmEvents;
            laneFifoErrorFlags <= (laneFifoErrorFlags & ~laneClear) | laneUpset;
        end
    end

    // summary, and pin in alarm mode, refreshed every cycle from the sticky bits; otherwise the pin follows calDone
    wire anyUnmasked = |(alarmStatusBits & ~alarmMaskBits);
    always @(posedge clock) begin
        if (reset) begin
            summaryAlarm <= 1'b0;
            calStatePin  <= 1'b0;
        end else begin
            summaryAlarm <= anyUnmasked;
            calStatePin  <= pinAlarm ? anyUnmasked : calDone;
        end
    end

    // ------------------------------------------------------------------------
    // axi4-lite read path
    // ------------------------------------------------------------------------
    assign s_axi_arready = ~s_axi_rvalid;
    reg [31:0] readWord;
    reg        readHit;
    // reserved bits read as zero
    always @* begin
        readWord = 32'h0000_0000;
        readHit  = 1'b1;
        case (s_axi_araddr)
            `SLA_OFS_CONTROL:   readWord[`SLA_CTL_WIDTH-1:0] = control;
            `SLA_OFS_EMPHASIS:  readWord[EMPH_W-1:0] = serializerEmphasisLevel;
            `SLA_OFS_ALM_STAT:  readWord[`SLA_ALM_COUNT-1:0] = alarmStatusBits;
            `SLA_OFS_ALARM_MASK_BITS:  readWord[`SLA_ALM_COUNT-1:0] = alarmMaskBits;
            `SLA_OFS_SUMMARY:   readWord[0] = summaryAlarm;
            `SLA_OFS_LANE_FIFO: readWord[LANES-1:0] = laneFifoErrorFlags;
            `SLA_OFS_FRAMING:   readWord[23:0] = {extMultiblockLength, frameLength};
            `SLA_OFS_STATE:     readWord[3:0] = {linkEnableLast, syncAsserted,
                                                 spllLocked, cpllLocked};
            default:            readHit = 1'b0;
        endcase
    end

    always @(posedge clock) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `SLA_RESP_OKAY;
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= readWord;
            s_axi_rresp  <= readHit ? `SLA_RESP_OKAY : `SLA_RESP_SLVERR;
        end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // sla_link_control

// ---- bench/sla_link_control_asserts.sv ----
`timescale 1ns/1ps
`include "sla_defines.vh"

module sla_link_control_asserts #(
    parameter EMPH_W = 4
) (
    // clock and reset
    input wire logic              clock,
    input wire logic              reset,
    // register bus
    input wire logic [7:0]        s_axi_awaddr,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    // pins and status
    input wire logic              syncRequestN,
    input wire logic              calDone,
    // link section control
    input wire logic              linkReset,
    input wire logic              serializerPowerDown,
    input wire logic              linkClockEnable,
    input wire logic              fifoReset,
    input wire logic [EMPH_W-1:0] serializerEmphasisLevel,
    input wire logic              localClockEdge,
    input wire logic              codeGroupSyncStart,
    // alarm reporting
    input wire logic              summaryAlarm,
    input wire logic              calStatePin
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // ------------------------------------------------------------
    // link enable effects
    // ------------------------------------------------------------
    property p_link_off;
        linkReset |-> serializerPowerDown && fifoReset && !linkClockEnable;
    endproperty
    a_link_off: assert property (p_link_off)
        else $error("link held off but section still active");
    property p_link_on;
        linkClockEnable |-> !serializerPowerDown && !linkReset && !fifoReset;
    endproperty
    a_link_on: assert property (p_link_on)
        else $error("link clocks on while section held down");
    // a gated section must not produce multiframe edges
    property p_lclk_off;
        linkReset && $past(linkReset) |-> !localClockEdge;
    endproperty
    a_lclk_off: assert property (p_lclk_off)
        else $error("local clock edge while link disabled");
    property p_fifo_rst;
        $fell(fifoReset) |-> $fell(linkReset);
    endproperty
    a_fifo_rst: assert property (p_fifo_rst)
        else $error("fifo reset released apart from link reset");
    // ------------------------------------------------------------
    // emphasis, code group start and alarm pin
    // ------------------------------------------------------------
    property p_emph;
        $changed(serializerEmphasisLevel) |->
            $past(s_axi_wvalid && s_axi_wready && s_axi_awaddr == `SLA_OFS_EMPHASIS);
    endproperty
    a_emph: assert property (p_emph)
        else $error("emphasis level changed without a write");
    property p_cgs_link;
        codeGroupSyncStart |-> !linkReset;
    endproperty
    a_cgs_link: assert property (p_cgs_link)
        else $error("code group start while link disabled");
    // the request passes two sync flops and a register
    property p_cgs_sync;
        $rose(codeGroupSyncStart) |-> !$past(syncRequestN, 3);
    endproperty
    a_cgs_sync: assert property (p_cgs_sync)
        else $error("code group start without a sync request");
    property p_pin;
        calStatePin != $past(calDone) |-> calStatePin == summaryAlarm;
    endproperty
    a_pin: assert property (p_pin)
        else $error("status pin neither cal state nor alarm");
endmodule // sla_link_control_asserts

bind sla_link_control sla_link_control_asserts #(.EMPH_W(EMPH_W)) u_chk (.*);

// ---- bench/sla_rx_model.sv ----
`timescale 1ns/1ps

module sla_rx_model (
    // clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // bench requests
    input  wire logic wantSync,
    input  wire logic fire,
    // transmitter side
    input  wire logic localClockEdge,
    output      logic syncRequestN = 1'b1,
    output      logic sysrefPin = 1'b0,
    output      int   edgeCount = 0
);
    int gap = 0;

    // the second pulse, 48 cycles on, lands off phase and must realign
    always @(posedge clock) begin
        if (fire)
            gap <= 52;
        else if (gap > 0)
            gap <= gap - 1;
        sysrefPin <= (gap > 48) || (gap > 0 && gap < 5);
    end

    // sync request follows the bench; edges counted as release points
    always @(posedge clock) begin
        syncRequestN <= reset || !wantSync;
        edgeCount <= edgeCount + int'(localClockEdge);
    end
endmodule // sla_rx_model

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`include "sla_defines.vh"

module testbench;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        clock = 0, reset = 1, upset = 0, wantSync = 0, fire = 0;
    logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0, laneFifoPointerUpset = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf, serializerEmphasisLevel;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
    logic        s_axi_bready = 1, s_axi_rready = 1;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        converterPllLock = 1, serializerPllLock = 1, linkInDataState = 1;
    logic        channelAPhase = 0, channelBPhase = 1, calDone = 1, sysrefPin, syncRequestN;
    logic        linkReset, serializerPowerDown, linkClockEnable, fifoReset, localClockEdge;
    logic        powerdownChannelA, powerdownChannelB, endOfExtMultiblock, codeGroupSyncStart;
    logic        summaryAlarm, calStatePin;
    int          edgeCount, errors = 0, checks_done = 0, n;

    always #5 clock = ~clock;
    // channel b tracks channel a unless an upset is injected
    always @(posedge clock) begin
        channelAPhase <= ~channelAPhase;
        channelBPhase <= ~channelAPhase ^ upset;
    end

    sla_link_control uut (.*);
    sla_rx_model rx (.clock, .reset, .wantSync, .fire, .localClockEdge, .syncRequestN,
        .sysrefPin, .edgeCount);

    // ------------------------------------------------------------
    // comparison, bus tasks and verdict
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    // address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = `SLA_RESP_OKAY);
        logic done;
        done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        while (!done) begin
            @(posedge clock);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
            if (s_axi_bvalid) done = 1;
        end
        check(s_axi_bresp, er);
    endtask
    task automatic rdChk(input logic [7:0] a, input logic [31:0] exp,
                         input logic [1:0] er = `SLA_RESP_OKAY);
        logic done;
        done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        while (!done) begin
            @(posedge clock);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
            if (s_axi_rvalid) done = 1;
        end
        check(s_axi_rdata, exp);
        check(s_axi_rresp, er);
    endtask
    task automatic conclude;
        $display("errors %0d, checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // a hung handshake ends the run here
    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        conclude();
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clock);
        reset <= 0;
        @(posedge clock);
        rdChk(`SLA_OFS_CONTROL, 32'h04);
        rdChk(`SLA_OFS_FRAMING, 32'h00010020);
        rdChk(`SLA_OFS_ALARM_MASK_BITS, 32'h0);
        wr(8'h40, 32'h1, `SLA_RESP_SLVERR);
        rdChk(8'h40, 32'h0, `SLA_RESP_SLVERR);
        wr(`SLA_OFS_EMPHASIS, 32'h0f);
        check(serializerEmphasisLevel, 32'hf);
        wr(`SLA_OFS_CONTROL, 32'h05);
        wr(`SLA_OFS_ALM_STAT, 32'h3f);
        check({linkReset, serializerPowerDown, fifoReset, linkClockEnable}, 32'h1);
        rdChk(`SLA_OFS_ALM_STAT, 32'h0);
        n = edgeCount;
        repeat (64) @(posedge clock);
        check(32'(edgeCount - n), 32'h2);
        // each alarm source in turn: set, report, clear
        for (int i = 0; i < 6; i++) begin
            case (i)
                0: converterPllLock <= 0;
                1: serializerPllLock <= 0;
                2: linkInDataState <= 0;
                3: fire <= 1;
                4: upset <= 1;
                default: laneFifoPointerUpset <= 8'h20;
            endcase
            @(posedge clock);
            {converterPllLock, serializerPllLock, linkInDataState} <= 3'b111;
            {fire, upset, laneFifoPointerUpset} <= 10'h0;
            repeat (100) @(posedge clock);
            rdChk(`SLA_OFS_ALM_STAT, 32'h1 << i);
            rdChk(`SLA_OFS_SUMMARY, 32'h1);
            if (i == 5) rdChk(`SLA_OFS_LANE_FIFO, 32'h20);
            wr(`SLA_OFS_LANE_FIFO, 32'hff);
            wr(`SLA_OFS_ALM_STAT, 32'h1 << i);
            rdChk(`SLA_OFS_ALM_STAT, 32'h0);
        end
        wr(`SLA_OFS_CONTROL, 32'h04);
        @(posedge clock);
        check(fifoReset, 32'h1);
        // masked alarm stays out of the summary
        wr(`SLA_OFS_ALARM_MASK_BITS, 32'h04);
        linkInDataState <= 0;
        repeat (4) @(posedge clock);
        rdChk(`SLA_OFS_ALM_STAT, 32'h04);
        rdChk(`SLA_OFS_SUMMARY, 32'h0);
        check(summaryAlarm, 32'h0);
        wr(`SLA_OFS_ALARM_MASK_BITS, 32'h0);
        repeat (3) @(posedge clock);
        check(summaryAlarm, 32'h1);
        // status pin in alarm mode, then back to cal state
        wr(`SLA_OFS_CONTROL, 32'h0c);
        calDone <= 0;
        repeat (3) @(posedge clock);
        check(calStatePin, 32'h1);
        linkInDataState <= 1;
        wr(`SLA_OFS_ALM_STAT, 32'h04);
        repeat (3) @(posedge clock);
        check(calStatePin, 32'h0);
        calDone <= 1;
        wr(`SLA_OFS_CONTROL, 32'h05);
        wantSync <= 1;
        repeat (8) @(posedge clock);
        check({calStatePin, codeGroupSyncStart, fifoReset}, 32'h6);
        // 64b/66b with two multiblocks per extended multiblock
        wr(`SLA_OFS_CONTROL, 32'h04);
        wr(`SLA_OFS_FRAMING, 32'h00020020);
        wr(`SLA_OFS_CONTROL, 32'h07);
        repeat (8) @(posedge clock);
        check(codeGroupSyncStart, 32'h0);
        n = 0;
        repeat (128) begin
            @(posedge clock);
            n += int'(endOfExtMultiblock);
        end
        check(32'(n), 32'd64);
        // subclass 0 ignores sysref entirely
        wr(`SLA_OFS_CONTROL, 32'h34);
        @(posedge clock);
        check({powerdownChannelA, powerdownChannelB}, 32'h3);
        wr(`SLA_OFS_CONTROL, 32'h03);
        wr(`SLA_OFS_ALM_STAT, 32'h3f);
        fire <= 1;
        @(posedge clock);
        fire <= 0;
        repeat (100) @(posedge clock);
        rdChk(`SLA_OFS_ALM_STAT, 32'h0);
        conclude();
    end
endmodule // testbench
